// *** sals_pkg.sv ***
// shared constants and types for the start-up / protection sequencer
package sals_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SAFETY_WAIT_US = 200;
  // least time: at least one cycle, no round-up
  localparam int unsigned SAFETY_WAIT_CYC =
    (SAFETY_WAIT_US * (CLK_HZ / 1000000) + 0) < 1 ? 1 :
    SAFETY_WAIT_US * (CLK_HZ / 1000000);
  localparam int unsigned REG_CYCLES = 8;
  localparam int unsigned OVP_EVENTS = 4;
  localparam int unsigned LATCH_THRESHOLD_MV = 3000;
  localparam int unsigned BLANK_CYC_DEF = 10;
  localparam int unsigned VALID_CYC_DEF = 20;
  localparam logic ARMED_RST = 1'b0;
  localparam logic LATCHED_RST = 1'b0;

  typedef enum logic [5:0] {
    SALS_IDLE   = 6'h01,
    SALS_WAIT   = 6'h02,
    SALS_RUN    = 6'h04,
    SALS_HICC1  = 6'h08,
    SALS_HICC2  = 6'h10,
    SALS_LATCH  = 6'h20
  } sals_state_t;
endpackage

// *** sals_ovp_if.sv ***
// link between the sequencer core and its over-voltage qualifier
interface sals_ovp_if;
  logic drv_off_pulse;
  logic cmp_hi;
  logic clear;
  logic event_pulse;
  logic count_full;
  modport core (output drv_off_pulse, output cmp_hi, output clear,
    input event_pulse, input count_full);
  modport qual (input drv_off_pulse, input cmp_hi, input clear,
    output event_pulse, output count_full);
endinterface

// *** sals_ovp_qual.sv ***
// over-voltage qualifier: blanking, minimum high time, event counter
module sals_ovp_qual #(
  parameter int unsigned BLANK_CYC = sals_pkg::BLANK_CYC_DEF,
  parameter int unsigned VALID_CYC = sals_pkg::VALID_CYC_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  sals_ovp_if.qual ovp
);
  logic [15:0] blank_r, blank_nxt;
  logic [15:0] hi_r, hi_nxt;
  logic done_r, done_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic ev_r, ev_nxt;

  always_comb begin
    blank_nxt = blank_r;
    hi_nxt = hi_r;
    done_nxt = done_r;
    cnt_nxt = cnt_r;
    ev_nxt = 1'b0;
    if (ovp.drv_off_pulse) begin
      blank_nxt = 16'(BLANK_CYC);
      hi_nxt = 16'h0000;
      done_nxt = 1'b0;
    end else if (blank_r != 16'h0000) begin
      blank_nxt = blank_r - 16'h0001;
    end else if (ovp.cmp_hi) begin
      if (!done_r) begin
        hi_nxt = hi_r + 16'h0001;
        if (hi_r + 16'h0001 >= 16'(VALID_CYC)) begin
          ev_nxt = 1'b1;
          done_nxt = 1'b1;
          if (cnt_r != 3'(sals_pkg::OVP_EVENTS))
            cnt_nxt = cnt_r + 3'h1;
        end
      end
    end else begin
      hi_nxt = 16'h0000; // short high discarded
    end
    if (ovp.clear)
      cnt_nxt = 3'h0;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      blank_r <= 16'h0000;
      hi_r <= 16'h0000;
      done_r <= 1'b0;
      cnt_r <= 3'h0;
      ev_r <= 1'b0;
    end else begin
      blank_r <= blank_nxt;
      hi_r <= hi_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      ev_r <= ev_nxt;
    end
  end

  assign ovp.event_pulse = ev_r;
  assign ovp.count_full = (cnt_r == 3'(sals_pkg::OVP_EVENTS));
endmodule

// *** sals_sequencer.sv ***
// start-up sequencer with armed flag, pre-short latch and ovp latch
////////////////////////////////////////////////////////////////////////
// Functional notes
// - grounded feedback suppresses every drive pulse
// - first pulse only after 200 us wait
// - arm on first pulse synchronised to turn-on
// - feedback grounded at turn-on: no arming
// - unarmed undervoltage: double hiccup, then latch
// - pulses allowed through first falling cycle
// - eight regulated cycles clear armed flag
// - feedback grounding during start-up clears arm
// - after supply reset, fresh start re-arms
// - latch stops pulses until supply reset
// - ignore comparator during blanking after turn-off
// - comparator high must last validation time
// - latch after four validated over-voltage events
// - trip above 3 V latch threshold
// - armed undervoltage latches immediately
// - pre-short logic only in latched variant
module sals_sequencer #(
  parameter bit PRESHORT_EN = 1'b1,
  parameter int unsigned SAFETY_CYC = sals_pkg::SAFETY_WAIT_CYC,
  parameter int unsigned BLANK_CYC = sals_pkg::BLANK_CYC_DEF,
  parameter int unsigned VALID_CYC = sals_pkg::VALID_CYC_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic supply_on_in,
  input wire logic supply_reset_in,
  input wire logic undervoltage_lockout_in,
  input wire logic feedback_grounded_in,
  input wire logic switch_tick_in,
  input wire logic drive_request_in,
  input wire logic below_peak_current_limit_in,
  input wire logic latch_cmp_in,
  output logic gate_drive_out,
  output logic armed_out,
  output logic latched_out,
  output logic overvoltage_event_out,
  output logic [5:0] state_out
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [7:0] s1_r, s2_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else begin
      s1_r <= {supply_on_in, supply_reset_in, undervoltage_lockout_in,
        feedback_grounded_in, switch_tick_in, drive_request_in,
        below_peak_current_limit_in, latch_cmp_in};
      s2_r <= s1_r;
    end
  end
  logic von, vrst, undervoltage_lockout, fbg, tick, dreq, below, cmp;
  assign {von, vrst, undervoltage_lockout, fbg, tick, dreq, below, cmp} = s2_r;

  logic von_d_r, undervoltage_lockout_d_r, tick_d_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      von_d_r <= 1'b0;
      undervoltage_lockout_d_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      von_d_r <= von;
      undervoltage_lockout_d_r <= undervoltage_lockout;
      tick_d_r <= tick;
    end
  end
  logic von_rise, undervoltage_lockout_rise, tick_rise;
  assign von_rise = von & ~von_d_r;
  assign undervoltage_lockout_rise = undervoltage_lockout & ~undervoltage_lockout_d_r;
  assign tick_rise = tick & ~tick_d_r;

  ////////////////////////////////////////////////////////////////////
  sals_ovp_if ovp ();
  sals_ovp_qual #(.BLANK_CYC(BLANK_CYC), .VALID_CYC(VALID_CYC)) u_qual (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ovp(ovp)
  );

  ////////////////////////////////////////////////////////////////////
  sals_pkg::sals_state_t state_r, state_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic armed_r, armed_nxt;
  logic sync_r, sync_nxt;      // feedback free at turn-on and through the wait
  logic first_r, first_nxt;    // no pulse yet in this start-up
  logic pulsed_r, pulsed_nxt;  // a pulse came in this supply cycle
  logic strike_r, strike_nxt;  // one unarmed undervoltage seen
  logic [3:0] reg_r, reg_nxt;
  logic drv_r, drv_nxt;

  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    armed_nxt = armed_r;
    sync_nxt = sync_r;
    first_nxt = first_r;
    pulsed_nxt = pulsed_r;
    strike_nxt = strike_r;
    reg_nxt = reg_r;
    drv_nxt = 1'b0;
    case (state_r)
      sals_pkg::SALS_IDLE: begin
        if (von_rise) begin
          state_nxt = sals_pkg::SALS_WAIT;
          wait_nxt = 16'(SAFETY_CYC);
          sync_nxt = ~fbg;
          first_nxt = 1'b1;
          pulsed_nxt = 1'b0;
          reg_nxt = 4'h0;
        end
      end
      sals_pkg::SALS_WAIT: begin
        if (fbg)
          sync_nxt = 1'b0;
        if (wait_r > 16'h0001)
          wait_nxt = wait_r - 16'h0001;
        else
          state_nxt = sals_pkg::SALS_RUN;
      end
      sals_pkg::SALS_RUN: begin
        // pulses run until the undervoltage event itself
        drv_nxt = dreq & ~fbg;
        if (drv_nxt) begin
          pulsed_nxt = 1'b1;
          first_nxt = 1'b0;
          if (first_r && sync_r && PRESHORT_EN)
            armed_nxt = 1'b1;
        end
        if (fbg && armed_r && reg_r != 4'(sals_pkg::REG_CYCLES))
          armed_nxt = 1'b0;
        if (tick_rise) begin
          if (below)
            reg_nxt = (reg_r == 4'(sals_pkg::REG_CYCLES)) ? reg_r
              : reg_r + 4'h1;
          else
            reg_nxt = 4'h0;
          if (below && reg_r + 4'h1 >= 4'(sals_pkg::REG_CYCLES))
            armed_nxt = 1'b0;
        end
        if (undervoltage_lockout_rise) begin
          drv_nxt = 1'b0;
          if (armed_r && PRESHORT_EN) begin
            state_nxt = sals_pkg::SALS_LATCH;
          end else if (strike_r && PRESHORT_EN) begin
            state_nxt = sals_pkg::SALS_LATCH;
          end else begin
            // no pulse in the falling cycle also hiccups
            strike_nxt = PRESHORT_EN;
            state_nxt = sals_pkg::SALS_HICC1;
          end
          armed_nxt = 1'b0;
        end
      end
      sals_pkg::SALS_HICC1: begin
        if (von_rise)
          state_nxt = sals_pkg::SALS_HICC2; // restart ignored once
      end
      sals_pkg::SALS_HICC2: begin
        if (von_rise) begin
          state_nxt = sals_pkg::SALS_WAIT;
          wait_nxt = 16'(SAFETY_CYC);
          sync_nxt = ~fbg;
          first_nxt = 1'b1;
          pulsed_nxt = 1'b0;
          reg_nxt = 4'h0;
        end
      end
      sals_pkg::SALS_LATCH: begin
        drv_nxt = 1'b0;
      end
      default: state_nxt = sals_pkg::SALS_IDLE;
    endcase
    if (ovp.count_full && state_r != sals_pkg::SALS_LATCH) begin
      state_nxt = sals_pkg::SALS_LATCH;
      drv_nxt = 1'b0;
    end
    // supply reset wins over everything
    if (vrst) begin
      state_nxt = sals_pkg::SALS_IDLE;
      armed_nxt = sals_pkg::ARMED_RST;
      strike_nxt = 1'b0;
      drv_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= sals_pkg::SALS_IDLE;
      wait_r <= 16'h0000;
      armed_r <= sals_pkg::ARMED_RST;
      sync_r <= 1'b0;
      first_r <= 1'b0;
      pulsed_r <= 1'b0;
      strike_r <= 1'b0;
      reg_r <= 4'h0;
      drv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      armed_r <= armed_nxt;
      sync_r <= sync_nxt;
      first_r <= first_nxt;
      pulsed_r <= pulsed_nxt;
      strike_r <= strike_nxt;
      reg_r <= reg_nxt;
      drv_r <= drv_nxt;
    end
  end

  // comparator only meaningful during off-time
  assign ovp.cmp_hi = cmp & ~drv_r;
  assign ovp.drv_off_pulse = drv_r & ~drv_nxt;
  assign ovp.clear = vrst;

  assign gate_drive_out = drv_r;
  assign armed_out = armed_r;
  assign latched_out = (state_r == sals_pkg::SALS_LATCH);
  assign overvoltage_event_out = ovp.event_pulse;
  assign state_out = state_r;
endmodule

// *** sals_sequencer_properties.sv ***
// concurrent checks on the sequencer top-level ports
module sals_seq_props #(
  parameter int unsigned SAFETY_CYC = 20
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic supply_reset_in,
  input wire logic undervoltage_lockout_in,
  input wire logic feedback_grounded_in,
  input wire logic latch_cmp_in,
  input wire logic gate_drive_out,
  input wire logic armed_out,
  input wire logic latched_out,
  input wire logic overvoltage_event_out,
  input wire logic [5:0] state_out
);
  int unsigned wait_cnt;
  logic [2:0] ev_cnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////
  // helpers: cycles spent waiting, validated events since supply reset
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cnt <= 0;
      ev_cnt <= 3'h0;
    end
    else begin
      wait_cnt <= (state_out == 6'h02) ? wait_cnt + 1 : 0;
      if (supply_reset_in)
        ev_cnt <= 3'h0;
      else if (overvoltage_event_out && ev_cnt != 3'h7)
        ev_cnt <= ev_cnt + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  property p_fb_gate;
    feedback_grounded_in [*5] |-> !gate_drive_out;
  endproperty
  a_fb_gate: assert property (p_fb_gate)
    else $error("drive while fb low");
  property p_wait;
    state_out == 6'h04 && $past(state_out) == 6'h02 |->
      wait_cnt >= SAFETY_CYC - 1;
  endproperty
  a_wait: assert property (p_wait)
    else $error("safety wait short");
  property p_drv_run;
    $rose(gate_drive_out) |->
      state_out == 6'h04 || $past(state_out) == 6'h04;
  endproperty
  a_drv_run: assert property (p_drv_run)
    else $error("drive out of run");
  property p_arm;
    $rose(armed_out) |-> gate_drive_out || $past(gate_drive_out);
  endproperty
  a_arm: assert property (p_arm)
    else $error("armed without drive");
  property p_arm_uv;
    armed_out && $rose(undervoltage_lockout_in) |-> ##[1:6] latched_out;
  endproperty
  a_arm_uv: assert property (p_arm_uv)
    else $error("armed undervoltage_lockout no latch");
  property p_quiet;
    latched_out && $past(latched_out) |-> !gate_drive_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("drive while latched");
  property p_valid;
    overvoltage_event_out |->
      $past(latch_cmp_in, 4) && $past(latch_cmp_in, 16);
  endproperty
  a_valid: assert property (p_valid)
    else $error("short high accepted");
  property p_fourth;
    overvoltage_event_out && ev_cnt == 3'h3 |-> ##[0:3] latched_out;
  endproperty
  a_fourth: assert property (p_fourth)
    else $error("no latch on 4th");
  property p_early;
    overvoltage_event_out && ev_cnt < 3'h3 && !latched_out |=> !latched_out;
  endproperty
  a_early: assert property (p_early)
    else $error("early ovp latch");
  property p_sres;
    supply_reset_in [*5] |-> !latched_out && !armed_out;
  endproperty
  a_sres: assert property (p_sres)
    else $error("supply reset no clear");
endmodule

// *** sals_master.sv ***
// supervisory master: grants or denies drive by grounding feedback
module sals_master (
  input wire logic deny_in,
  output logic feedback_grounded_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // no filtering: the master may ground feedback at any moment
  assign feedback_grounded_out = deny_in;
endmodule

// *** sals_sequencer_bench.sv ***
// self-checking bench for the start-up / protection sequencer
module sals_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SAFE = 20;
  // comparator highs lost to blanking plus the two sync stages
  localparam int BL = int'(sals_pkg::BLANK_CYC_DEF) + 2;
  localparam int VAL = int'(sals_pkg::VALID_CYC_DEF);
  localparam int OV_N = int'(sals_pkg::OVP_EVENTS);
  logic clk, rst, son, sres, uv, deny, fbg, below, cmp;
  logic tick = 1'b0, req = 1'b0;
  logic gate, armed, latched, ovev;
  logic [5:0] state;
  logic armed_ar, latched_ar;
  int ov_model = 0;
  int err_count = 0, num_checks = 0, cyc = 0, ev_seen = 0, mode = 0;
  integer seed = 32'hc8df;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sals_sequencer #(.SAFETY_CYC(SAFE)) DUT (.sys_clk_in(clk), .rst_in(rst),
    .supply_on_in(son), .supply_reset_in(sres), .undervoltage_lockout_in(uv),
    .feedback_grounded_in(fbg), .switch_tick_in(tick), .drive_request_in(req),
    .below_peak_current_limit_in(below), .latch_cmp_in(cmp),
    .gate_drive_out(gate), .armed_out(armed), .latched_out(latched),
    .overvoltage_event_out(ovev), .state_out(state));
  sals_master u_master (.deny_in(deny), .feedback_grounded_out(fbg));
  // auto-recovery variant beside the latched one, same stimulus
  sals_sequencer #(.PRESHORT_EN(1'b0), .SAFETY_CYC(SAFE)) DUT_AR (
    .sys_clk_in(clk), .rst_in(rst), .supply_on_in(son),
    .supply_reset_in(sres), .undervoltage_lockout_in(uv),
    .feedback_grounded_in(fbg), .switch_tick_in(tick),
    .drive_request_in(req), .below_peak_current_limit_in(below),
    .latch_cmp_in(cmp), .gate_drive_out(), .armed_out(armed_ar),
    .latched_out(latched_ar), .overvoltage_event_out(), .state_out());
  ////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    tick <= cyc[2];
    req <= (mode == 2) ? 1'($random(seed)) : (mode == 1);
    // sampled mid-cycle, where the registered pulse has settled
    if (ovev === 1'b1)
      ev_seen <= ev_seen + 1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [5:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic turn_on(input int settle);
    son = 1'b0;
    step(2);
    son = 1'b1;
    step(settle);
  endtask
  // the far side pulls the supply down to force a fresh soft-start
  task automatic power_cycle();
    sres = 1'b1;
    son = 1'b0;
    step(8);
    chk("latched", 6'(latched), 6'h0);
    sres = 1'b0;
    step(4);
  endtask
  task automatic undervoltage_lockout();
    uv = 1'b1;
    son = 1'b0;
    step(6);
    uv = 1'b0;
    step(4);
  endtask
  task automatic ovp(input int dly, input int hold);
    int hi;
    hi = (dly >= BL) ? hold : hold + dly - BL;
    mode = 1;
    step(8);
    mode = 0;
    step(dly);
    cmp = 1'b1;
    step(hold);
    cmp = 1'b0;
    step(6);
    if (hi >= VAL && ov_model < OV_N)
      ov_model++;
    chk("ov_model", 6'(ev_seen), 6'(ov_model));
    chk("ov_latch", 6'(latched), 6'(ov_model >= OV_N));
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {son, sres, uv, deny, below, cmp} = 6'h00;
    step(6);
    rst = 1'b0;
    step(4);
    mode = 2;
    turn_on(0);
    repeat (SAFE) begin
      step(1);
      chk("gate_wait", 6'(gate), 6'h0);
    end
    step(SAFE);
    chk("armed", 6'(armed), 6'h1);
    chk("armed_ar", 6'(armed_ar), 6'h0);
    undervoltage_lockout();
    chk("latched", 6'(latched), 6'h1);
    chk("gate", 6'(gate), 6'h0);
    chk("latched_ar", 6'(latched_ar), 6'h0);
    power_cycle();
    turn_on(2 * SAFE);
    chk("armed", 6'(armed), 6'h1);
    deny = 1'b1;
    step(8);
    chk("gate", 6'(gate), 6'h0);
    chk("armed", 6'(armed), 6'h0);
    deny = 1'b0;
    undervoltage_lockout();
    chk("state", state, 6'h08);
    turn_on(8);
    chk("state", state, 6'h10);
    turn_on(2 * SAFE);
    // clear the fresh arming so only the earlier strike can latch
    deny = 1'b1;
    step(8);
    chk("armed", 6'(armed), 6'h0);
    deny = 1'b0;
    undervoltage_lockout();
    chk("latched", 6'(latched), 6'h1);
    chk("latched_ar", 6'(latched_ar), 6'h0);
    power_cycle();
    deny = 1'b1;
    turn_on(SAFE + 8);
    deny = 1'b0;
    step(SAFE);
    chk("armed", 6'(armed), 6'h0);
    power_cycle();
    turn_on(2 * SAFE);
    below = 1'b1;
    step(40);
    chk("armed", 6'(armed), 6'h1);
    step(48);
    chk("armed", 6'(armed), 6'h0);
    // supply falling but no lockout yet: drive must still pass
    mode = 1;
    son = 1'b0;
    step(6);
    chk("gate_fall", 6'(gate), 6'h1);
    undervoltage_lockout();
    chk("latched", 6'(latched), 6'h0);
    below = 1'b0;
    power_cycle();
    turn_on(2 * SAFE);
    // high starting inside blanking, then one after it, both too short to validate
    ovp(0, 25);
    ovp(14, 15);
    chk("ov_events", 6'(ev_seen), 6'h0);
    for (int i = 0; i < 4; i++) begin
      ovp(14, 30);
      chk("latched", 6'(latched), 6'(i == 3));
    end
    chk("ov_events", 6'(ev_seen), 6'h4);
    power_cycle();
    tally_and_finish();
  end
endmodule
bind sals_sequencer sals_seq_props #(.SAFETY_CYC(SAFETY_CYC)) u_props (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .supply_reset_in(supply_reset_in),
  .undervoltage_lockout_in(undervoltage_lockout_in),
  .feedback_grounded_in(feedback_grounded_in), .latch_cmp_in(latch_cmp_in),
  .gate_drive_out(gate_drive_out), .armed_out(armed_out),
  .latched_out(latched_out), .overvoltage_event_out(overvoltage_event_out),
  .state_out(state_out));
